// ### hw/dmm_defines.vh
// Purpose: Shared constants of the digital mixing matrix
// Assumes: Signed 24-bit samples, unsigned 16-bit gains
// Notes: Gain 16'h8000 is unity; gain zero means maximum attenuation
`ifndef DMM_DEFINES_VH
`define DMM_DEFINES_VH

`define DMM_NCH 26
`define DMM_NSRC 52
`define DMM_NPAIR 13
`define DMM_NMETER 78
`define DMM_SW 24
`define DMM_GW 16
`define DMM_PW 8
`define DMM_ACCW 32
`define DMM_RAM_AW 10
`define DMM_RAM_DEPTH 676
`define DMM_GAIN_UNITY 16'h8000
`define DMM_GAIN_MA 16'h0000
`define DMM_GAIN_SHIFT 15
`define DMM_PAN_FULL 8'h80
`define DMM_PAN_SHIFT 7
`define DMM_DS_NCH 5'h0E
`define DMM_RMS_SHIFT 12
`define DMM_FS_POS 24'h7FFFFF
`define DMM_FS_NEG 24'h800000
`define DMM_OUT_METER_BASE 7'h34

`endif

// ### hw/dmm_route_ram.v
// Purpose: Route settings store, one word per source and output pair
// Assumes: Single clock, one write port and one read port
// Notes: Read data is registered, so it appears one cycle after the address
`timescale 1ns/1ps
module dmm_route_ram #(
	parameter DW = 24,
	parameter AW = 10,
	parameter DEPTH = 676
) (
	mclk,
	we,
	waddr,
	wdata,
	raddr,
	rdata
);
	input wire mclk;
	input wire we;
	input wire [AW-1:0] waddr;
	input wire [DW-1:0] wdata;
	input wire [AW-1:0] raddr;
	output reg [DW-1:0] rdata;

	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge mclk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule // dmm_route_ram

// ### hw/dmm_matrix.v
// Purpose: Digital mixing matrix: 52 sources into 26 outputs, metering, record path
// Assumes: Sources arrive one sample at a time; frame_tick marks each sample period
// Notes: A source sample costs 15 cycles; dead double-speed channels are skipped
// Behaviour
// (RULE1) Accept 26 input and 26 playback sources, drive 26 hardware outputs.
// (RULE2) Any source routes to any output; contributions to an output are summed.
// (RULE3) One source may feed many outputs, each route with its own gain.
// (RULE4) Record path passes inputs unchanged except in loopback, which records the mix.
// (RULE5) Peak and RMS for inputs and playback; only peak for outputs.
// (RULE6) Source meters pre-gain; output meters after all gains and summing.
// (RULE7) Peak has zero attack; one full-scale sample shows full scale.
// (RULE8) Each metered channel flags overload for software to show.
// (RULE9) Each output applies its own level gain to the summed mix.
// (RULE10) Each route pans its contribution between the output pair's left and right.
// (RULE11) A route is active and keeps its gain once gain is not maximum attenuation.
// (RULE12) Controlling software loads 1:1 playback routing at 0 dB by default.
// (RULE13) At least 13 independent stereo mixes with own per-source gains.
// (RULE14) Gain at maximum attenuation deactivates the route.
// (RULE15) Double speed drops upper optical channels; stored gains stay unchanged.
// (RULE16) Sum each output once per sample period, saturating instead of wrapping.
// (RULE17) Mean-square meter uses a long averaging time constant.
`timescale 1ns/1ps
`include "dmm_defines.vh"
module dmm_matrix #(
	parameter RMS_SHIFT = `DMM_RMS_SHIFT
) (
	input wire mclk,
	input wire rstn,
	input wire frame_tick,
	input wire ds_mode,
	input wire loopback_en,
	input wire src_valid,
	output wire src_ready,
	input wire [5:0] src_idx,
	input wire [23:0] src_data,
	input wire cfg_route_we,
	input wire [5:0] cfg_src,
	input wire [3:0] cfg_pair,
	input wire [15:0] cfg_gain,
	input wire [7:0] cfg_pan,
	input wire cfg_out_we,
	input wire [4:0] cfg_out_idx,
	input wire [15:0] cfg_out_gain,
	output reg out_valid,
	output reg [4:0] out_idx,
	output reg [23:0] out_data,
	output reg rec_valid,
	output reg [4:0] rec_idx,
	output reg [23:0] rec_data,
	input wire [6:0] meter_idx,
	input wire meter_clr,
	output reg [23:0] meter_peak,
	output reg [23:0] meter_ms,
	output reg meter_over
);
	localparam ST_IDLE = 3'b001;
	localparam ST_MIX = 3'b010;
	localparam ST_DUMP = 3'b100;
	function live;
		input [4:0] ch;
		input ds;
		live = !(ds && ch >= `DMM_DS_NCH); // RULE15
	endfunction
	// The product is 32 bits wide; only the low address bits are kept
	function [9:0] route_addr;
		input [5:0] s;
		input [3:0] p;
		reg [31:0] t;
		begin
			t = s * `DMM_NPAIR + p;
			route_addr = t[9:0];
		end
	endfunction
	function [23:0] sat24;
		input signed [47:0] v;
		begin
			if (v > $signed({24'h000000, `DMM_FS_POS}))
				sat24 = `DMM_FS_POS;
			else if (v < $signed({24'hFFFFFF, `DMM_FS_NEG}))
				sat24 = `DMM_FS_NEG;
			else
				sat24 = v[23:0];
		end
	endfunction
	reg [2:0] state_r;
	reg dump_pend_r;
	reg [5:0] s_r;
	reg [23:0] x_r;
	reg [3:0] p_r;
	reg [3:0] pq_r;
	reg pv_r;
	reg [4:0] o_r;
	reg signed [31:0] acc_r [0:`DMM_NCH-1];
	reg [15:0] og_r [0:`DMM_NCH-1];
	reg [23:0] pk_r [0:`DMM_NMETER-1];
	reg [23:0] ms_r [0:`DMM_NSRC-1];
	reg ov_r [0:`DMM_NMETER-1];
	wire [23:0] rt_q;
	integer i;
	integer j;
	// Accepted sources and pre-gain meter values
	wire src_go = state_r == ST_IDLE && !dump_pend_r && src_valid;
	wire src_hw = src_idx < `DMM_NCH;
	wire [4:0] src_ch = src_hw ? src_idx[4:0] : (src_idx[4:0] - 5'h1A);
	wire src_ok = src_idx < `DMM_NSRC && live(src_ch, ds_mode);
	wire [23:0] src_abs = src_data[23] ? (~src_data + 24'h000001) : src_data; // RULE6
	wire signed [47:0] src_sq = $signed(src_data) * $signed(src_data);

	// Route contribution for the pair whose word is leaving the store
	wire [15:0] r_gain = rt_q[23:8];
	wire [7:0] r_pan = (rt_q[7:0] > `DMM_PAN_FULL) ? `DMM_PAN_FULL : rt_q[7:0];
	wire signed [47:0] x48 = {{24{x_r[23]}}, x_r};
	wire signed [47:0] scaled = (x48 * $signed({32'h00000000, r_gain})) >>> `DMM_GAIN_SHIFT; // RULE3
	wire signed [47:0] c_left = (scaled * $signed({40'h0000000000, `DMM_PAN_FULL - r_pan})) >>> `DMM_PAN_SHIFT; // RULE10
	wire signed [47:0] c_right = (scaled * $signed({40'h0000000000, r_pan})) >>> `DMM_PAN_SHIFT; // RULE10
	wire [4:0] dst_l = {pq_r, 1'b0};
	wire route_on = r_gain != `DMM_GAIN_MA; // RULE11 RULE14

	// Output stage: saturate the sum, apply the output level, saturate again
	wire signed [31:0] acc_o = acc_r[o_r];
	wire [23:0] sum_sat = sat24({{16{acc_o[31]}}, acc_o}); // RULE16
	wire signed [47:0] lvl = ($signed({{24{sum_sat[23]}}, sum_sat}) * $signed({32'h00000000, og_r[o_r]}))
		>>> `DMM_GAIN_SHIFT; // RULE9
	wire [23:0] o_val = live(o_r, ds_mode) ? sat24(lvl) : 24'h000000;
	wire [23:0] o_abs = o_val[23] ? (~o_val + 24'h000001) : o_val;
	wire o_over = live(o_r, ds_mode) && (sum_sat != acc_o[23:0] || o_val != lvl[23:0] ||
		o_val == `DMM_FS_POS || o_val == `DMM_FS_NEG);
	wire [6:0] o_mi = `DMM_OUT_METER_BASE + {2'b00, o_r};

	// Meter update port, shared by source arrival and output dump
	wire m_upd = src_go && src_idx < `DMM_NSRC || state_r == ST_DUMP;
	wire [6:0] m_i = state_r == ST_DUMP ? o_mi : {1'b0, src_idx};
	wire [23:0] m_abs = state_r == ST_DUMP ? o_abs : src_abs;
	wire m_ovr = state_r == ST_DUMP ? o_over : (src_data == `DMM_FS_POS || src_data == `DMM_FS_NEG);
	wire signed [24:0] ms_cur = {1'b0, ms_r[src_idx]};
	wire signed [24:0] ms_new = {1'b0, src_sq[45:22]};
	wire signed [24:0] ms_step = (ms_new - ms_cur) >>> RMS_SHIFT; // RULE17

	assign src_ready = state_r == ST_IDLE && !dump_pend_r;
	dmm_route_ram #(
		.DW(24),
		.AW(`DMM_RAM_AW),
		.DEPTH(`DMM_RAM_DEPTH)
	) u_ram (
		.mclk(mclk),
		.we(cfg_route_we && cfg_src < `DMM_NSRC && cfg_pair < `DMM_NPAIR), // RULE3
		.waddr(route_addr(cfg_src, cfg_pair)),
		.wdata({cfg_gain, cfg_pan}),
		.raddr(route_addr(s_r, p_r)),
		.rdata(rt_q)
	);

	always @(posedge mclk)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			dump_pend_r <= 1'b0;
			s_r <= 6'h00;
			x_r <= 24'h000000;
			p_r <= 4'h0;
			pq_r <= 4'h0;
			pv_r <= 1'b0;
			o_r <= 5'h00;
			out_valid <= 1'b0;
			out_idx <= 5'h00;
			out_data <= 24'h000000;
			rec_valid <= 1'b0;
			rec_idx <= 5'h00;
			rec_data <= 24'h000000;
			for (i = 0; i < `DMM_NCH; i = i + 1)
			begin
				acc_r[i] <= 32'h00000000;
				og_r[i] <= `DMM_GAIN_UNITY;
			end
		end
		else
		begin
			// A tick in the same cycle as the dump start is kept
			dump_pend_r <= frame_tick || (dump_pend_r && state_r != ST_IDLE); // RULE16
			out_valid <= 1'b0;
			rec_valid <= 1'b0;
			if (cfg_out_we && cfg_out_idx < `DMM_NCH)
				og_r[cfg_out_idx] <= cfg_out_gain; // RULE9
			case (state_r)
				ST_IDLE:
				begin
					if (dump_pend_r)
					begin
						state_r <= ST_DUMP;
						o_r <= 5'h00;
					end
					else if (src_valid)
					begin
						s_r <= src_idx;
						x_r <= src_data;
						p_r <= 4'h0;
						pv_r <= 1'b0;
						if (src_hw && !loopback_en)
						begin
							rec_valid <= 1'b1; // RULE4
							rec_idx <= src_idx[4:0];
							rec_data <= src_data;
						end
						if (src_ok)
							state_r <= ST_MIX; // RULE1 RULE2
					end
				end
				ST_MIX:
				begin
					if (p_r < `DMM_NPAIR)
					begin
						pv_r <= 1'b1;
						pq_r <= p_r;
						p_r <= p_r + 4'h1;
					end
					else
						pv_r <= 1'b0;
					// Every pair has its own route word, so 13 stereo mixes stay independent
					if (pv_r && route_on)
					begin
						if (live(dst_l, ds_mode))
							acc_r[dst_l] <= acc_r[dst_l] + c_left[31:0]; // RULE2 RULE13
						if (live(dst_l + 5'h01, ds_mode))
							acc_r[dst_l + 5'h01] <= acc_r[dst_l + 5'h01] + c_right[31:0]; // RULE2 RULE13
					end
					if (pv_r && p_r == `DMM_NPAIR)
						state_r <= ST_IDLE;
				end
				ST_DUMP:
				begin
					out_valid <= 1'b1; // RULE1
					out_idx <= o_r;
					out_data <= o_val;
					if (loopback_en)
					begin
						rec_valid <= 1'b1; // RULE4
						rec_idx <= o_r;
						rec_data <= o_val;
					end
					acc_r[o_r] <= 32'h00000000; // RULE16
					o_r <= o_r + 5'h01;
					if (o_r == `DMM_NCH - 1)
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Meters: a new sample in the clearing cycle wins over the clear
	always @(posedge mclk)
	begin
		if (!rstn)
		begin
			for (j = 0; j < `DMM_NMETER; j = j + 1)
			begin
				pk_r[j] <= 24'h000000;
				ov_r[j] <= 1'b0;
			end
			for (j = 0; j < `DMM_NSRC; j = j + 1)
				ms_r[j] <= 24'h000000;
			meter_peak <= 24'h000000;
			meter_ms <= 24'h000000;
			meter_over <= 1'b0;
		end
		else
		begin
			if (meter_clr && meter_idx < `DMM_NMETER)
			begin
				pk_r[meter_idx] <= 24'h000000;
				ov_r[meter_idx] <= 1'b0; // RULE8
			end
			if (m_upd)
			begin
				if (m_abs > pk_r[m_i] || (meter_clr && meter_idx == m_i))
					pk_r[m_i] <= m_abs; // RULE5 RULE7
				if (m_ovr)
					ov_r[m_i] <= 1'b1; // RULE8
				if (state_r != ST_DUMP)
					ms_r[src_idx] <= ms_cur[23:0] + ms_step[23:0]; // RULE5 RULE6
			end
			if (meter_idx < `DMM_NMETER)
			begin
				meter_peak <= pk_r[meter_idx];
				meter_over <= ov_r[meter_idx];
				meter_ms <= (meter_idx < `DMM_NSRC) ? ms_r[meter_idx[5:0]] : 24'h000000;
			end
			else
			begin
				meter_peak <= 24'h000000;
				meter_over <= 1'b0;
				meter_ms <= 24'h000000;
			end
		end
	end
endmodule // dmm_matrix

// ### tb/dmm_matrix_monitor.sv
// Purpose: Port checks of the mixing matrix
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every dmm_matrix instance
`timescale 1ns/1ps
module dmm_matrix_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ds_mode,
	input wire logic loopback_en,
	input wire logic src_valid,
	input wire logic src_ready,
	input wire logic [5:0] src_idx,
	input wire logic [23:0] src_data,
	input wire logic rec_valid,
	input wire logic [4:0] rec_idx,
	input wire logic [23:0] rec_data,
	input wire logic out_valid,
	input wire logic [4:0] out_idx,
	input wire logic [23:0] out_data,
	input wire logic [6:0] meter_idx,
	input wire logic [23:0] meter_ms
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_take;
		src_valid && src_ready && !ds_mode && src_idx < 6'h34;
	endsequence
	// A tick during the mix keeps ready low and starts the dump instead
	sequence s_busy;
		(!src_ready)[*8] ##7 (src_ready or (!src_ready ##2 $rose(out_valid)));
	endsequence
	a_ready_drop: assert property (s_take |=> !src_ready)
		else $error("ready kept after sample");
	a_ready_back: assert property (s_take |=> s_busy)
		else $error("mix time wrong");
	a_rec_pass: assert property (src_valid && src_ready && src_idx < 6'h1A && !loopback_en
		|=> rec_valid && rec_idx == $past(src_idx[4:0]) && rec_data == $past(src_data))
		else $error("record differs");
	a_out_first: assert property ($rose(out_valid) |-> out_idx == 5'h00)
		else $error("dump start index");
	a_out_step: assert property (out_valid && out_idx < 5'h19
		|=> out_valid && out_idx == $past(out_idx) + 5'h01)
		else $error("dump order");
	a_out_end: assert property (out_valid && out_idx == 5'h19 |=> !out_valid)
		else $error("dump too long");
	a_ds_dead: assert property (ds_mode && out_valid && out_idx > 5'h0D |-> out_data == 24'h000000)
		else $error("dead output live");
	a_ms_none: assert property ($past(meter_idx) > 7'h33 |-> meter_ms == 24'h000000)
		else $error("output mean square");
endmodule // dmm_matrix_chk

bind dmm_matrix dmm_matrix_chk u_chk (.mclk(mclk), .rstn(rstn), .ds_mode(ds_mode),
	.loopback_en(loopback_en), .src_valid(src_valid), .src_ready(src_ready), .src_idx(src_idx),
	.src_data(src_data), .rec_valid(rec_valid), .rec_idx(rec_idx), .rec_data(rec_data),
	.out_valid(out_valid), .out_idx(out_idx), .out_data(out_data), .meter_idx(meter_idx),
	.meter_ms(meter_ms));

// ### tb/dmm_src_model.sv
// Purpose: Source stream partner of the mixing matrix
// Assumes: Ready is settled 1 ns after an edge
// Notes: Released lines are inverted so stale data never matches
`timescale 1ns/1ps
module dmm_src_model (
	input wire logic mclk,
	input wire logic src_ready,
	output logic src_valid,
	output logic [5:0] src_idx,
	output logic [23:0] src_data
);
	initial
	begin
		src_valid = 1'b0;
		src_idx = 6'h00;
		src_data = 24'h000000;
	end
	task automatic send(input logic [5:0] i, input logic [23:0] d, input int w);
		repeat (w) @(posedge mclk);
		@(posedge mclk);
		#1 src_valid = 1'b1;
		src_idx = i;
		src_data = d;
		while (src_ready !== 1'b1)
			@(posedge mclk) #1;
		@(posedge mclk);
		#1 src_valid = 1'b0;
		src_idx = ~src_idx;
		src_data = ~src_data;
	endtask
endmodule // dmm_src_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the mixing matrix
// Assumes: 50 MHz clock, inputs driven 1 ns after each edge
// Notes: Route store has no reset, so every word is written first
`timescale 1ns/1ps
module tb_top;
	logic mclk = 0, rstn = 0, frame_tick = 0, ds_mode = 0, loopback_en = 0, meter_clr = 0;
	logic cfg_route_we = 0, cfg_out_we = 0, src_valid, src_ready, out_valid, rec_valid, meter_over;
	logic [5:0] src_idx, cfg_src = 0;
	logic [3:0] cfg_pair = 0;
	logic [15:0] cfg_gain = 0, cfg_out_gain = 0;
	logic [7:0] cfg_pan = 0;
	logic [4:0] cfg_out_idx = 0, out_idx, rec_idx;
	logic [6:0] meter_idx = 0;
	logic [23:0] src_data, out_data, rec_data, meter_peak, meter_ms;
	logic [23:0] ex [0:25], got [0:25], rg [0:25];
	int n_errors = 0, num_checks = 0;
	dmm_matrix #(.RMS_SHIFT(2)) i_dut (.mclk(mclk), .rstn(rstn), .frame_tick(frame_tick), .ds_mode(ds_mode),
		.loopback_en(loopback_en), .src_valid(src_valid), .src_ready(src_ready), .src_idx(src_idx),
		.src_data(src_data), .cfg_route_we(cfg_route_we), .cfg_src(cfg_src), .cfg_pair(cfg_pair),
		.cfg_gain(cfg_gain), .cfg_pan(cfg_pan), .cfg_out_we(cfg_out_we), .cfg_out_idx(cfg_out_idx),
		.cfg_out_gain(cfg_out_gain), .out_valid(out_valid), .out_idx(out_idx), .out_data(out_data),
		.rec_valid(rec_valid), .rec_idx(rec_idx), .rec_data(rec_data), .meter_idx(meter_idx),
		.meter_clr(meter_clr), .meter_peak(meter_peak), .meter_ms(meter_ms), .meter_over(meter_over));
	dmm_src_model i_src (.mclk(mclk), .src_ready(src_ready), .src_valid(src_valid), .src_idx(src_idx),
		.src_data(src_data));
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic route(input logic [5:0] s, input logic [3:0] p, input logic [15:0] g, input logic [7:0] pn);
		@(posedge mclk);
		#1 cfg_route_we = 1;
		{cfg_src, cfg_pair, cfg_gain, cfg_pan} = {s, p, g, pn};
		@(posedge mclk);
		#1 cfg_route_we = 0;
	endtask
	task automatic meter(input logic [6:0] m, input logic [23:0] pk, input logic [23:0] ms, input logic ov);
		@(posedge mclk);
		#1 meter_idx = m;
		repeat (2) @(posedge mclk);
		#1 chk("peak", pk, meter_peak);
		chk("mean square", ms, meter_ms);
		chk("over", 24'(ov), 24'(meter_over));
	endtask
	// Mixing needs 15 cycles per sample; tick only once it is done
	task automatic frame;
		int k = 0;
		repeat (15) @(posedge mclk);
		#1 frame_tick = 1;
		@(posedge mclk);
		#1 frame_tick = 0;
		for (int i = 0; i < 60 && k < 26; i++)
		begin
			@(posedge mclk);
			#1;
			if (out_valid === 1'b1)
			begin
				got[out_idx] = out_data;
				rg[out_idx] = rec_data;
				k++;
			end
		end
		chk("words", 24'd26, 24'(k));
		for (int i = 0; i < 26; i++)
			chk($sformatf("out%0d", i), ex[i], got[i]);
	endtask
	task automatic t_mix;
		for (int s = 0; s < 52; s++)
			for (int p = 0; p < 13; p++)
				route(6'(s), 4'(p), 16'h0000, 8'h00);
		foreach (ex[i])
			ex[i] = 24'h000000;
		route(6'h00, 4'h0, 16'h4000, 8'h00);
		route(6'h1A, 4'h0, 16'h8000, 8'h00);
		route(6'h1A, 4'h1, 16'h8000, 8'h80);
		i_src.send(6'h00, 24'h000100, 0);
		chk("record", 24'h000100, rec_data);
		chk("record index", 24'h000000, 24'(rec_idx));
		i_src.send(6'h1A, 24'h000200, 3);
		ex[0] = 24'h000280;
		ex[3] = 24'h000200;
		frame();
		meter(7'h00, 24'h000100, 24'h000000, 1'b0);
		meter(7'h34, 24'h000280, 24'h000000, 1'b0);
		$display("mix done");
	endtask
	task automatic t_saturate;
		i_src.send(6'h1A, 24'h7FFFFF, 0);
		i_src.send(6'h1A, 24'h7FFFFF, 0);
		ex[0] = 24'h7FFFFF;
		ex[3] = 24'h7FFFFF;
		frame();
		// Two full-scale samples through the leaky mean square at shift 2
		meter(7'h1A, 24'h7FFFFF, 24'h6FFFFE, 1'b1);
		meter(7'h34, 24'h7FFFFF, 24'h000000, 1'b1);
		meter(7'h7F, 24'h000000, 24'h000000, 1'b0);
		@(posedge mclk);
		#1 meter_idx = 7'h1A;
		meter_clr = 1;
		@(posedge mclk);
		#1 meter_clr = 0;
		meter(7'h1A, 24'h000000, 24'h6FFFFE, 1'b0);
		$display("saturate done");
	endtask
	task automatic t_level;
		@(posedge mclk);
		#1 {cfg_out_we, cfg_out_idx, cfg_out_gain, loopback_en} = {1'b1, 5'h03, 16'h4000, 1'b1};
		@(posedge mclk);
		#1 cfg_out_we = 0;
		route(6'h1A, 4'h0, 16'h0000, 8'h00);
		i_src.send(6'h00, 24'h000100, 0);
		i_src.send(6'h1A, 24'h000200, 0);
		ex[0] = 24'h000080;
		ex[3] = 24'h000100;
		frame();
		chk("loop0", ex[0], rg[0]);
		chk("loop3", ex[3], rg[3]);
		$display("level done");
	endtask
	task automatic t_double;
		route(6'h1A, 4'hC, 16'h8000, 8'h00);
		@(posedge mclk);
		#1 {ds_mode, loopback_en} = 2'b10;
		i_src.send(6'h1A, 24'h000200, 0);
		ex[0] = 24'h000000;
		frame();
		@(posedge mclk);
		#1 ds_mode = 0;
		i_src.send(6'h1A, 24'h000200, 0);
		ex[24] = 24'h000200;
		frame();
		$display("double done");
	endtask
	// Software's start-up routing: each playback channel to its own output at unity
	task automatic t_default;
		route(6'h1A, 4'h1, 16'h0000, 8'h00);
		route(6'h1A, 4'hC, 16'h0000, 8'h00);
		for (int c = 0; c < 26; c++)
		begin
			route(6'(26 + c), 4'(c / 2), 16'h8000, (c % 2 == 1) ? 8'h80 : 8'h00);
			i_src.send(6'(26 + c), 24'(16 * (c + 1)), 0);
			ex[c] = (c == 3) ? 24'(8 * (c + 1)) : 24'(16 * (c + 1));
		end
		frame();
		$display("default done");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_errors++;
		$display("watchdog expired");
		conclude;
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		#1 rstn = 1;
		t_mix();
		t_saturate();
		t_level();
		t_double();
		t_default();
		conclude;
	end
endmodule // tb_top
